// File: rtl/bcsp_pkg.sv
package bcsp_pkg;

	// --------------------------------------------------------------
	// Register map
	// --------------------------------------------------------------
	localparam logic [15:0] BCSP_CTRL1_ADDR = 16'h1F96;
	localparam logic [15:0] BCSP_CTRL2_ADDR = 16'h1F97;
	localparam logic [15:0] BCSP_STAT_ADDR = 16'h1F95;
	localparam logic [15:0] BCSP_BUF_BASE = 16'h1F98;

	// --------------------------------------------------------------
	// Field positions and reset values
	// --------------------------------------------------------------
	localparam int BCSP_START_BIT = 7;
	localparam int BCSP_ABORT_BIT = 6;
	localparam int BCSP_MODE_LSB = 3;
	localparam int BCSP_SCK_LSB = 0;
	localparam int BCSP_WAIT_LSB = 3;
	localparam int BCSP_COUNT_LSB = 0;
	localparam int BCSP_INPROC_BIT = 7;
	localparam int BCSP_SHACT_BIT = 6;
	localparam logic [7:0] BCSP_CTRL1_RST = 8'h00;
	localparam logic [7:0] BCSP_CTRL2_RST = 8'h00;
	localparam logic [7:0] BCSP_DUMMY = 8'hFF;

	// --------------------------------------------------------------
	// Mode and clock codes
	// --------------------------------------------------------------
	localparam logic [2:0] BCSP_MODE_TX8 = 3'h0;
	localparam logic [2:0] BCSP_MODE_TX4 = 3'h2;
	localparam logic [2:0] BCSP_MODE_TXRX8 = 3'h4;
	localparam logic [2:0] BCSP_MODE_RX8 = 3'h5;
	localparam logic [2:0] BCSP_MODE_RX4 = 3'h6;
	localparam logic [2:0] BCSP_SCK_EXT = 3'h7;

	// --------------------------------------------------------------
	// Cycle counts: half periods of the internal serial clock; gap unit in half periods
	// --------------------------------------------------------------
	localparam logic [12:0] BCSP_HALF_0 = 13'h1000;
	localparam logic [12:0] BCSP_HALF_1 = 13'h0080;
	localparam logic [12:0] BCSP_HALF_2 = 13'h0040;
	localparam logic [12:0] BCSP_HALF_3 = 13'h0020;
	localparam logic [12:0] BCSP_HALF_4 = 13'h0010;
	localparam logic [12:0] BCSP_HALF_5 = 13'h0008;
	localparam logic [6:0] BCSP_GAP_UNIT = 7'h10;

	typedef enum logic [3:0] {
		BCSP_IDLE = 4'b0001,
		BCSP_SHIFT = 4'b0010,
		BCSP_AWAIT = 4'b0100,
		BCSP_GAP = 4'b1000
	} bcsp_state_type;

endpackage

// File: rtl/bcsp_port.sv
`timescale 1ns/1ps
module bcsp_port
	import bcsp_pkg::*;
(
	input wire logic SYS_CLK,
	input wire logic RST_N,
	input wire logic CLK_EN,
	input wire logic [15:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [7:0] RDATA,
	input wire logic SCK_I,
	output logic SCK_O,
	output logic SCK_OE,
	input wire logic SI,
	output logic SO,
	output logic IRQ
);

	// --------------------------------------------------------------
	// Declarations
	// --------------------------------------------------------------
	bcsp_state_type state_reg;
	logic start_reg;
	logic [2:0] mode_reg;
	logic [2:0] sck_sel_reg;
	logic [1:0] wait_reg;
	logic [2:0] count_reg;
	logic inproc_reg;
	logic serviced_reg;
	logic dummy_reg;
	logic irq_reg;
	logic [2:0] idx_reg;
	logic [2:0] bit_reg;
	logic [7:0] tx_sh_reg;
	logic [7:0] rx_sh_reg;
	logic [12:0] div_reg;
	logic [6:0] gap_reg;
	logic sck_o_reg;
	logic sck_oe_reg;
	logic so_reg;
	logic [7:0] rdata_reg;
	logic [7:0] word_buf_reg [0:7];
	logic sck_s1, sck_s2, sck_s3, sck_lvl_reg;
	logic si_s1, si_s2, si_s3, si_lvl_reg;
	logic four_bit, is_tx, is_rx, ext;
	logic buf_hit, buf_wr, buf_rd, buf_access;
	logic ctrl1_wr, ctrl2_wr, abort_req, start_wr, mode_chg;
	logic [12:0] half_cnt;
	logic tick_raw, tick, ext_fall, ext_rise, fall_ev, rise_ev;
	logic [2:0] last_bit;
	logic word_end, set_end, cancel, serv_now, rx_store;
	logic [7:0] rx_next, rx_val;
	logic [3:0] gap_mul;
	logic [6:0] gap_ld;

	// --------------------------------------------------------------
	// Decode
	// --------------------------------------------------------------
	// mode decode
	assign four_bit = (mode_reg == BCSP_MODE_TX4) || (mode_reg == BCSP_MODE_RX4);
	assign is_tx = (mode_reg == BCSP_MODE_TX8) || (mode_reg == BCSP_MODE_TX4)
		|| (mode_reg == BCSP_MODE_TXRX8);
	assign is_rx = (mode_reg == BCSP_MODE_RX8) || (mode_reg == BCSP_MODE_RX4)
		|| (mode_reg == BCSP_MODE_TXRX8);
	assign ext = (sck_sel_reg == BCSP_SCK_EXT);
	assign last_bit = four_bit ? 3'h3 : 3'h7;
	assign buf_hit = (ADDR[15:3] == BCSP_BUF_BASE[15:3]);
	assign buf_wr = WR && buf_hit;
	assign buf_rd = RD && buf_hit;
	assign buf_access = buf_wr || buf_rd;
	assign ctrl1_wr = WR && (ADDR == BCSP_CTRL1_ADDR);
	assign ctrl2_wr = WR && (ADDR == BCSP_CTRL2_ADDR);
	assign abort_req = ctrl1_wr && WDATA[BCSP_ABORT_BIT];
	assign start_wr = ctrl1_wr && WDATA[BCSP_START_BIT];
	assign mode_chg = ctrl1_wr && (WDATA[BCSP_MODE_LSB +: 3] != mode_reg);

	// --------------------------------------------------------------
	// Pin synchronisers
	// --------------------------------------------------------------
	// filter relies on wide external pulses
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			sck_s1 <= 1'b1;
			sck_s2 <= 1'b1;
			sck_s3 <= 1'b1;
			sck_lvl_reg <= 1'b1;
			si_s1 <= 1'b1;
			si_s2 <= 1'b1;
			si_s3 <= 1'b1;
			si_lvl_reg <= 1'b1;
		end else if (CLK_EN) begin
			sck_s1 <= SCK_I;
			sck_s2 <= sck_s1;
			sck_s3 <= sck_s2;
			if (sck_s2 == sck_s3)
				sck_lvl_reg <= sck_s3;
			si_s1 <= SI;
			si_s2 <= si_s1;
			si_s3 <= si_s2;
			if (si_s2 == si_s3)
				si_lvl_reg <= si_s3;
		end
	end

	assign ext_fall = CLK_EN && ext && (sck_s2 == sck_s3) && sck_lvl_reg
		&& !sck_s3;
	assign ext_rise = CLK_EN && ext && (sck_s2 == sck_s3) && !sck_lvl_reg
		&& sck_s3;

	// --------------------------------------------------------------
	// Internal serial clock
	// --------------------------------------------------------------
	// clock source select
	always_comb begin
		unique case (sck_sel_reg)
			3'h0: half_cnt = BCSP_HALF_0;
			3'h1: half_cnt = BCSP_HALF_1;
			3'h2: half_cnt = BCSP_HALF_2;
			3'h3: half_cnt = BCSP_HALF_3;
			3'h4: half_cnt = BCSP_HALF_4;
			default: half_cnt = BCSP_HALF_5;
		endcase
	end

	assign tick_raw = CLK_EN && !ext && (div_reg == half_cnt - 13'h0001);
	assign tick = tick_raw && (state_reg == BCSP_SHIFT);
	// leading edge is the pin fall
	assign fall_ev = (state_reg == BCSP_SHIFT)
		&& (ext ? ext_fall : (tick && sck_o_reg));
	// trailing edge is the pin rise
	assign rise_ev = (state_reg == BCSP_SHIFT)
		&& (ext ? ext_rise : (tick && !sck_o_reg));
	assign word_end = rise_ev && (bit_reg == last_bit);
	assign set_end = word_end && (idx_reg == count_reg);
	assign serv_now = serviced_reg || buf_access;
	// external receive overrun cancels
	// Only armed after a completed round, so the first word always lands
	assign cancel = ext && is_rx && dummy_reg && !serv_now;
	assign rx_store = word_end && is_rx && !cancel && !abort_req;
	assign rx_next = {si_lvl_reg, rx_sh_reg[7:1]};
	// nibble store with zero upper half
	assign rx_val = four_bit ? {4'h0, rx_next[7:4]} : rx_next;
	assign gap_mul = (4'h1 << wait_reg) - 4'h1;
	assign gap_ld = (!ext && ((mode_reg == BCSP_MODE_RX8)
		|| (mode_reg == BCSP_MODE_TXRX8)))
		? 7'({4'h0, gap_mul[2:0]} * BCSP_GAP_UNIT) : 7'h00;

	// Divider only runs while a frame is live, so idle costs no toggling
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			div_reg <= 13'h0000;
		end else if (CLK_EN) begin
			if (!ext && ((state_reg == BCSP_SHIFT) || (state_reg == BCSP_GAP)))
				div_reg <= tick_raw ? 13'h0000 : div_reg + 13'h0001;
			else
				div_reg <= 13'h0000;
		end
	end

	// drive clock pin, high at start
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			sck_o_reg <= 1'b1;
			sck_oe_reg <= 1'b0;
		end else if (CLK_EN) begin
			sck_oe_reg <= !ext;
			if (tick)
				sck_o_reg <= !sck_o_reg;
			else if (state_reg == BCSP_IDLE)
				sck_o_reg <= 1'b1;
		end
	end

	property p_sck_start;
		@(posedge SYS_CLK) disable iff (!RST_N)
		$rose(inproc_reg) && !ext |-> sck_o_reg ##1 sck_o_reg;
	endproperty
	a_sck_start: assert property (p_sck_start)
		else $error("clock pin not high at transfer start");

	// --------------------------------------------------------------
	// Shift data path
	// --------------------------------------------------------------
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			so_reg <= 1'b1;
			rx_sh_reg <= 8'h00;
		end else if (CLK_EN) begin
			if (fall_ev && is_tx)
				so_reg <= tx_sh_reg[bit_reg];
			else if (state_reg == BCSP_IDLE)
				so_reg <= 1'b1;
			// sample on rise, LSB first in
			if (rise_ev && is_rx)
				rx_sh_reg <= rx_next;
		end
	end

	property p_so_edge;
		@(posedge SYS_CLK) disable iff (!RST_N)
		$changed(so_reg) && inproc_reg && $past(inproc_reg) |-> $past(fall_ev);
	endproperty
	a_so_edge: assert property (p_so_edge)
		else $error("serial out changed away from a falling edge");

	property p_rx_edge;
		@(posedge SYS_CLK) disable iff (!RST_N)
		$changed(rx_sh_reg) |-> $past(rise_ev);
	endproperty
	a_rx_edge: assert property (p_rx_edge)
		else $error("receive shifter moved away from a rising edge");

	// --------------------------------------------------------------
	// Control registers
	// --------------------------------------------------------------
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			start_reg <= BCSP_CTRL1_RST[BCSP_START_BIT];
			mode_reg <= BCSP_CTRL1_RST[BCSP_MODE_LSB +: 3];
			sck_sel_reg <= BCSP_CTRL1_RST[BCSP_SCK_LSB +: 3];
			wait_reg <= BCSP_CTRL2_RST[BCSP_WAIT_LSB +: 2];
			count_reg <= BCSP_CTRL2_RST[BCSP_COUNT_LSB +: 3];
		end else if (CLK_EN) begin
			if (ctrl1_wr) begin
				// Abort bit is never stored: it self-clears
				start_reg <= WDATA[BCSP_START_BIT] && !WDATA[BCSP_ABORT_BIT];
				mode_reg <= WDATA[BCSP_MODE_LSB +: 3];
				sck_sel_reg <= WDATA[BCSP_SCK_LSB +: 3];
			end
			if (ctrl2_wr) begin
				wait_reg <= WDATA[BCSP_WAIT_LSB +: 2];
				count_reg <= WDATA[BCSP_COUNT_LSB +: 3];
			end
		end
	end

	// --------------------------------------------------------------
	// Word buffer
	// --------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : g_entry
			always_ff @(posedge SYS_CLK or negedge RST_N) begin
				if (!RST_N) begin
					word_buf_reg[g] <= 8'h00;
				end else if (CLK_EN) begin
					if (mode_chg)
						word_buf_reg[g] <= 8'h00;
					else if (rx_store && (idx_reg == 3'(g)))
						word_buf_reg[g] <= rx_val;
					else if (buf_wr && (ADDR[2:0] == 3'(g)))
						word_buf_reg[g] <= WDATA;
				end
			end
		end
	endgenerate

	property p_nibble;
		@(posedge SYS_CLK) disable iff (!RST_N)
		rx_store && four_bit && !mode_chg |=>
			word_buf_reg[$past(idx_reg)][7:4] == 4'h0;
	endproperty
	a_nibble: assert property (p_nibble)
		else $error("4-bit receive left upper nibble set");

	// --------------------------------------------------------------
	// Service tracking
	// --------------------------------------------------------------
	// any entry counts, set wins over clear
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N)
			serviced_reg <= 1'b0;
		else if (CLK_EN) begin
			// Start clears it: the initial fill belongs to the first round
			if (buf_access)
				serviced_reg <= 1'b1;
			else if (set_end || ((state_reg == BCSP_IDLE) && start_wr))
				serviced_reg <= 1'b0;
		end
	end

	// --------------------------------------------------------------
	// Transfer sequencer
	// --------------------------------------------------------------
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			state_reg <= BCSP_IDLE;
			inproc_reg <= 1'b0;
			idx_reg <= 3'h0;
			bit_reg <= 3'h0;
			dummy_reg <= 1'b0;
			irq_reg <= 1'b0;
			gap_reg <= 7'h00;
			tx_sh_reg <= 8'h00;
		end else if (CLK_EN) begin
			irq_reg <= set_end && !abort_req && !cancel;
			if (abort_req) begin
				state_reg <= BCSP_IDLE;
				inproc_reg <= 1'b0;
			end else begin
				unique case (state_reg)
					BCSP_IDLE: begin
						if (start_wr) begin
							state_reg <= BCSP_SHIFT;
							inproc_reg <= 1'b1;
							idx_reg <= 3'h0;
							bit_reg <= 3'h0;
							dummy_reg <= 1'b0;
							tx_sh_reg <= word_buf_reg[0];
						end
					end
					BCSP_SHIFT: begin
						if (word_end) begin
							bit_reg <= 3'h0;
							if (cancel || (dummy_reg && !is_rx) || !start_reg) begin
								state_reg <= BCSP_IDLE;
								inproc_reg <= 1'b0;
							end else begin
								idx_reg <= set_end ? 3'h0 : idx_reg + 3'h1;
								gap_reg <= gap_ld;
								if (set_end && !ext && !serv_now)
									state_reg <= BCSP_AWAIT;
								else
									state_reg <= BCSP_GAP;
								dummy_reg <= set_end && ext && !serv_now;
							end
						end else if (rise_ev) begin
							bit_reg <= bit_reg + 3'h1;
						end
					end
					BCSP_AWAIT: begin
						if (!start_reg) begin
							state_reg <= BCSP_IDLE;
							inproc_reg <= 1'b0;
						end else if (buf_access) begin
							state_reg <= BCSP_GAP;
						end
					end
					BCSP_GAP: begin
						tx_sh_reg <= dummy_reg ? BCSP_DUMMY : word_buf_reg[idx_reg];
						if (!start_reg) begin
							state_reg <= BCSP_IDLE;
							inproc_reg <= 1'b0;
						end else if (gap_reg == 7'h00) begin
							state_reg <= BCSP_SHIFT;
						end else if (tick_raw) begin
							gap_reg <= gap_reg - 7'h01;
						end
					end
				endcase
			end
		end
	end

	sequence s_wait2;
		(state_reg == BCSP_AWAIT) [*2];
	endsequence

	property p_wait_hold;
		@(posedge SYS_CLK) disable iff (!RST_N)
		s_wait2 |-> $stable(sck_o_reg) && $stable(so_reg);
	endproperty
	a_wait_hold: assert property (p_wait_hold)
		else $error("serial clock moved during automatic wait");

	property p_wait_exit;
		@(posedge SYS_CLK) disable iff (!RST_N)
		(state_reg == BCSP_AWAIT) && CLK_EN && buf_access |=>
			(state_reg != BCSP_AWAIT);
	endproperty
	a_wait_exit: assert property (p_wait_exit)
		else $error("buffer access did not release automatic wait");

	property p_abort;
		@(posedge SYS_CLK) disable iff (!RST_N)
		CLK_EN && abort_req |=> !inproc_reg && (state_reg == BCSP_IDLE);
	endproperty
	a_abort: assert property (p_abort)
		else $error("abort did not end the transfer");

	property p_irq;
		@(posedge SYS_CLK) disable iff (!RST_N)
		irq_reg |-> $past(set_end) && $past(idx_reg) == $past(count_reg);
	endproperty
	a_irq: assert property (p_irq)
		else $error("interrupt without the set word count");

	// --------------------------------------------------------------
	// Read port
	// --------------------------------------------------------------
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			rdata_reg <= 8'h00;
		end else if (CLK_EN) begin
			rdata_reg <= 8'h00;
			if (buf_rd)
				rdata_reg <= word_buf_reg[ADDR[2:0]];
			else if (RD && (ADDR == BCSP_STAT_ADDR)) begin
				rdata_reg[BCSP_INPROC_BIT] <= inproc_reg;
				rdata_reg[BCSP_SHACT_BIT] <= (state_reg == BCSP_SHIFT);
			end
		end
	end

	sequence s_stat_rd_wait;
		RD && CLK_EN && (ADDR == BCSP_STAT_ADDR) && (state_reg == BCSP_AWAIT);
	endsequence

	property p_shact;
		@(posedge SYS_CLK) disable iff (!RST_N)
		s_stat_rd_wait |=> !rdata_reg[BCSP_SHACT_BIT]
			&& rdata_reg[BCSP_INPROC_BIT];
	endproperty
	a_shact: assert property (p_shact)
		else $error("shift-active shown during automatic wait");

	// --------------------------------------------------------------
	// Outputs
	// --------------------------------------------------------------
	assign RDATA = rdata_reg;
	assign SCK_O = sck_o_reg;
	assign SCK_OE = sck_oe_reg;
	assign SO = so_reg;
	assign IRQ = irq_reg;

endmodule

// File: testbench/bcsp_peer.sv
`timescale 1ns/1ps
module bcsp_peer (
	input wire logic sck_o,
	input wire logic sck_oe,
	input wire logic so,
	output logic sck_pin,
	output logic si
);
	// ------------------------------------------------------------
	// Clock pin and data lines
	// ------------------------------------------------------------
	logic ext_lvl = 1'h1;
	logic si_q[$];
	logic so_q[$];

	// Pull-up holds the pin high when nobody drives it
	assign sck_pin = sck_oe ? sck_o : ext_lvl;

	initial si = 1'h0;

	// Idle data toggles so a stale bit never reads as valid
	always @(negedge sck_pin) begin
		if (si_q.size() > 0) begin
			si <= si_q.pop_front();
		end else begin
			si <= ~si;
		end
	end

	always @(posedge sck_pin) begin
		so_q.push_back(so);
	end

	function automatic void feed(input logic [7:0] v, input int nb);
		for (int b = 0; b < nb; b++) begin
			si_q.push_back(v[b]);
		end
	endfunction

	// ------------------------------------------------------------
	// External clock, only within a frame
	// ------------------------------------------------------------
	// Odd start offset keeps the link out of phase with the system clock
	// wide filtered pulses
	task automatic run_ext(input int n);
		#7;
		repeat (n) begin
			ext_lvl = 1'h0;
			#32;
			ext_lvl = 1'h1;
			#32;
		end
	endtask
endmodule

// File: testbench/tb.sv
`timescale 1ns/1ps
module tb;
	import bcsp_pkg::*;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic sys_clk = 1'h0;
	logic rst_n = 1'h0;
	logic [15:0] addr = 16'h0000;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'h0;
	logic rd = 1'h0;
	logic clk_en = 1'h1;
	logic [7:0] rdata;
	logic sck_o, sck_oe, so, irq, sck_pin, si;
	int mismatches = 0;
	int n_tests = 0;
	int cyc = 0;
	logic exp_q[$];
	logic [7:0] w[8];

	always #2.5 sys_clk = ~sys_clk;

	bcsp_port i_bcsp_port (.SYS_CLK(sys_clk), .RST_N(rst_n), .CLK_EN(clk_en),
		.ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
		.SCK_I(sck_pin), .SCK_O(sck_o), .SCK_OE(sck_oe), .SI(si),
		.SO(so), .IRQ(irq));
	bcsp_peer i_bcsp_peer (.sck_o(sck_o), .sck_oe(sck_oe), .so(so),
		.sck_pin(sck_pin), .si(si));

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED %0t got %h want %h", $time, seen, exp);
		end
	endtask

	task automatic bus_wr(input logic [15:0] a, input logic [7:0] v);
		@(posedge sys_clk);
		addr <= a;
		wdata <= v;
		wr <= 1'h1;
		@(posedge sys_clk);
		wr <= 1'h0;
		#1;
	endtask

	task automatic bus_rd(input logic [15:0] a);
		@(posedge sys_clk);
		addr <= a;
		rd <= 1'h1;
		@(posedge sys_clk);
		rd <= 1'h0;
		#1;
	endtask

	task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
		bus_rd(a);
		chk(rdata, e);
	endtask

	task automatic wait_sig(input bit want_irq);
		int k;
		k = 0;
		while ((want_irq ? irq : ~sck_o) !== 1'h1 && k < 20000) begin
			@(posedge sys_clk);
			#1;
			k++;
		end
		chk({7'h00, want_irq ? irq : ~sck_o}, 8'h01);
	endtask

	// Polls status; a buffer access here would release a wait
	task automatic wait_idle();
		int k;
		k = 0;
		do begin
			bus_rd(BCSP_STAT_ADDR);
			k++;
		end while (rdata !== 8'h00 && k < 4000);
		chk(rdata, 8'h00);
	endtask

	task automatic hold_high();
		repeat (40) begin
			@(posedge sys_clk);
			#1;
			chk({7'h00, sck_o}, 8'h01);
		end
	endtask

	function automatic void push_exp(input logic [7:0] v, input int nb);
		for (int b = 0; b < nb; b++) begin
			exp_q.push_back(v[b]);
		end
	endfunction

	task automatic cmp_bits();
		chk(8'(i_bcsp_peer.so_q.size()), 8'(exp_q.size()));
		foreach (exp_q[i]) begin
			chk({7'h00, i_bcsp_peer.so_q[i]}, {7'h00, exp_q[i]});
		end
	endtask

	task automatic setup(input logic [2:0] m, input logic [2:0] ck, int n);
		bus_wr(BCSP_CTRL1_ADDR, {2'h1, m, ck});
		bus_wr(BCSP_CTRL2_ADDR, 8'(n - 1));
		i_bcsp_peer.so_q.delete();
		i_bcsp_peer.si_q.delete();
		exp_q.delete();
	endtask

	task automatic tx_int(input logic [2:0] m, input int nb);
		int n;
		n = 1 + $urandom_range(6);
		setup(m, 3'h5, n);
		for (int i = 0; i < n; i++) begin
			w[i] = 8'($urandom);
			bus_wr(BCSP_BUF_BASE + 16'(i), w[i]);
			push_exp(w[i], nb);
		end
		bus_wr(BCSP_CTRL1_ADDR, {2'h2, m, 3'h5});
		chk({6'h00, sck_oe, sck_o}, 8'h03);
		wait_sig(1'h1);
		cmp_bits();
		rd_chk(BCSP_STAT_ADDR, 8'h80);
		hold_high();
		i_bcsp_peer.so_q.delete();
		exp_q.delete();
		push_exp(w[0], nb);
		bus_wr(BCSP_BUF_BASE + 16'h0007, 8'(n));
		wait_sig(1'h0);
		bus_wr(BCSP_CTRL1_ADDR, {2'h0, m, 3'h5});
		wait_idle();
		cmp_bits();
		$display("test internal transmit done");
	endtask

	task automatic rx_int(input logic [2:0] m, input int nb);
		int n;
		logic [7:0] e;
		n = 1 + $urandom_range(6);
		setup(m, 3'h5, n);
		for (int i = 0; i < n; i++) begin
			w[i] = 8'($urandom);
			i_bcsp_peer.feed(w[i], nb);
		end
		bus_wr(BCSP_CTRL1_ADDR, {2'h2, m, 3'h5});
		wait_sig(1'h1);
		hold_high();
		rd_chk(BCSP_STAT_ADDR, 8'h80);
		for (int i = 0; i < n; i++) begin
			e = (nb == 4) ? {4'h0, w[i][3:0]} : w[i];
			rd_chk(BCSP_BUF_BASE + 16'(i), e);
		end
		bus_wr(BCSP_CTRL1_ADDR, {2'h1, m, 3'h5});
		rd_chk(BCSP_STAT_ADDR, 8'h00);
		$display("test internal receive done");
	endtask

	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 60000) begin
			mismatches++;
			give_verdict();
		end
	end

	initial begin
		void'($urandom(75));
		repeat (5) @(posedge sys_clk);
		#1;
		chk(rdata, 8'h00);
		chk({4'h0, sck_o, sck_oe, so, irq}, 8'h0A);
		@(posedge sys_clk);
		rst_n <= 1'h1;
		rd_chk(BCSP_STAT_ADDR, 8'h00);
		rd_chk(BCSP_CTRL1_ADDR, 8'h00);
		rd_chk(16'h0000, 8'h00);
		bus_wr(BCSP_BUF_BASE + 16'h0003, 8'hA5);
		rd_chk(BCSP_BUF_BASE + 16'h0003, 8'hA5);
		bus_wr(BCSP_CTRL1_ADDR, {2'h1, BCSP_MODE_RX8, 3'h0});
		rd_chk(BCSP_BUF_BASE + 16'h0003, 8'h00);
		// Frozen clock enable must drop a write
		@(posedge sys_clk);
		clk_en <= 1'h0;
		bus_wr(BCSP_BUF_BASE + 16'h0003, 8'h5A);
		@(posedge sys_clk);
		clk_en <= 1'h1;
		rd_chk(BCSP_BUF_BASE + 16'h0003, 8'h00);
		for (int c = 0; c < 8; c++) begin
			bus_wr(BCSP_CTRL1_ADDR, {2'h1, BCSP_MODE_TXRX8, 3'(c)});
			// Output enable follows the select one flop later
			@(posedge sys_clk);
			#1;
			chk({7'h00, sck_oe}, {7'h00, c != 7});
		end
		$display("test registers done");
		tx_int(BCSP_MODE_TX8, 8);
		tx_int(BCSP_MODE_TX4, 4);
		rx_int(BCSP_MODE_RX8, 8);
		rx_int(BCSP_MODE_RX4, 4);
		setup(BCSP_MODE_TX8, BCSP_SCK_EXT, 1);
		w[0] = 8'($urandom);
		bus_wr(BCSP_BUF_BASE, w[0]);
		push_exp(w[0], 8);
		push_exp(BCSP_DUMMY, 8);
		bus_wr(BCSP_CTRL1_ADDR, {2'h2, BCSP_MODE_TX8, BCSP_SCK_EXT});
		chk({6'h00, sck_oe, so}, 8'h01);
		i_bcsp_peer.run_ext(16);
		wait_idle();
		cmp_bits();
		setup(BCSP_MODE_RX8, BCSP_SCK_EXT, 1);
		w[0] = 8'($urandom);
		w[1] = 8'($urandom);
		i_bcsp_peer.feed(w[0], 8);
		i_bcsp_peer.feed(w[1], 8);
		bus_wr(BCSP_CTRL1_ADDR, {2'h2, BCSP_MODE_RX8, BCSP_SCK_EXT});
		i_bcsp_peer.run_ext(16);
		wait_idle();
		rd_chk(BCSP_BUF_BASE, w[0]);
		$display("test external clock done");
		give_verdict();
	end
endmodule
